// >>> pkg/ccp_pwm_consts.svh
// register offsets, field positions, reset values and counts of the capture/compare pwm
`ifndef CCP_PWM_CONSTS_SVH
`define CCP_PWM_CONSTS_SVH

`define ADDR_W          8
`define OFS_PWM_CONTROL 8'h00
`define OFS_DUTY_BUF    8'h04
`define OFS_DUTY_ACT    8'h08
`define OFS_TSEL        8'h0c
`define OFS_TCTL0       8'h10
`define OFS_PLIM0       8'h1c
`define OFS_PCNT0       8'h28
`define OFS_STATUS      8'h34
`define OFS_PIN_DIR     8'h38
`define OFS_STEER       8'h3c

`define REG_NONE        5'h1f
`define REG_CONTROL     5'h00
`define REG_DUTY_BUF    5'h01
`define REG_DUTY_ACT    5'h02
`define REG_TSEL        5'h03
`define REG_TCTL0       5'h04
`define REG_PLIM0       5'h07
`define REG_PCNT0       5'h0a
`define REG_STATUS      5'h0d
`define REG_PIN_DIR     5'h0e
`define REG_STEER       5'h0f

`define CTL_MODE_LSB    6
`define CTL_LOW_LSB     4
`define CTL_PWM_ON      2'h3
`define TCTL_RUN_BIT    2
`define TCTL_POST_LSB   3
`define TCTL_RST        7'h00
`define PLIM_RST        8'hff
`define PIN_DIR_RST     4'hf
`define STEER_RST       4'h1

`define PSC_LAST_1      6'h03
`define PSC_LAST_4      6'h0f
`define PSC_LAST_16     6'h3f

`endif

// >>> pkg/ccp_pwm_pkg.sv
// types shared by the pwm timers and the pwm generator
package ccp_pwm_pkg;
	typedef enum logic [1:0]
	{
		MODE_SINGLE   = 2'b00,
		MODE_FULL_FWD = 2'b01,
		MODE_HALF     = 2'b10,
		MODE_FULL_REV = 2'b11
	} mode_type;

	typedef enum logic [1:0]
	{
		ARM_IDLE = 2'b00,
		ARM_WAIT = 2'b01,
		ARM_RUN  = 2'b10
	} arm_type;

	typedef enum logic [1:0]
	{
		PSC_1  = 2'b00,
		PSC_4  = 2'b01,
		PSC_16 = 2'b10
	} psc_type;
endpackage

// >>> pkg/pwm_timer_if.sv
// link between the register side of the pwm and its period timers
interface pwm_timer_if #(parameter int NT = 3);
	logic [NT-1:0]      runEnable;
	logic [NT-1:0][1:0] prescale;
	logic [NT-1:0][7:0] periodLimit;
	logic [NT-1:0][7:0] count;
	logic [NT-1:0][9:0] timeBaseNext;
	logic [NT-1:0]      wrapNow;

	modport ctrl  (output runEnable, prescale, periodLimit, input count, timeBaseNext, wrapNow);
	modport timer (input runEnable, prescale, periodLimit, output count, timeBaseNext, wrapNow);
endinterface

// >>> hw/ccp_period_timers.sv
// the selectable 8-bit period timers with their prescalers
`include "ccp_pwm_consts.svh"
module ccp_period_timers
	import ccp_pwm_pkg::*;
#(
	parameter int NT = 3
)
(
	input wire logic    ref_clk,
	input wire logic    srst,
	pwm_timer_if.timer  tif
);
	if (NT < 1 || NT > 3)
	begin
		$error("NT must be 1 to 3");
	end

	typedef struct packed
	{
		logic [NT-1:0][5:0] psc;
		logic [NT-1:0][7:0] cnt;
	} tstate_type;

	tstate_type         st_ff;
	tstate_type         nxt_st;
	logic [NT-1:0]      wrap;
	logic [NT-1:0][9:0] tbn;

	function automatic logic [5:0] psc_last(input logic [1:0] sel);
		case (sel)
			PSC_1:   psc_last = `PSC_LAST_1;
			PSC_4:   psc_last = `PSC_LAST_4;
			default: psc_last = `PSC_LAST_16;
		endcase
	endfunction

	// the two bits under the counter are the clock phase at 1:1, else the top prescaler bits
	function automatic logic [1:0] tb_low(input logic [5:0] psc, input logic [1:0] sel);
		case (sel)
			PSC_1:   tb_low = psc[1:0];
			PSC_4:   tb_low = psc[3:2];
			default: tb_low = psc[5:4];
		endcase
	endfunction

	always_comb
	begin
		nxt_st = st_ff;
		wrap = '0;
		for (int i = 0; i < NT; i++)
		begin
			if (tif.runEnable[i])
			begin
				if (st_ff.psc[i] == psc_last(tif.prescale[i]))
				begin
					nxt_st.psc[i] = 6'h00;
					if (st_ff.cnt[i] == tif.periodLimit[i])
					begin
						nxt_st.cnt[i] = 8'h00;
						wrap[i] = 1'b1;
					end
					else
						nxt_st.cnt[i] = st_ff.cnt[i] + 8'h01;
				end
				else
					nxt_st.psc[i] = st_ff.psc[i] + 6'h01;
			end
			tbn[i] = {nxt_st.cnt[i], tb_low(nxt_st.psc[i], tif.prescale[i])};
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign tif.wrapNow      = wrap;
	assign tif.timeBaseNext = tbn;
	assign tif.count        = st_ff.cnt;
endmodule

// >>> hw/ccp_pwm_gen.sv
// capture/compare pwm generator with enhanced output steering and an apb register file
`include "ccp_pwm_consts.svh"
module ccp_pwm_gen
	import ccp_pwm_pkg::*;
#(
	parameter int NUM_TIMERS = 3
)
(
	input wire logic                ref_clk,
	input wire logic                srst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [`ADDR_W-1:0]  paddr,
	input wire logic [31:0]         pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic [3:0]              pinOut,
	output logic [3:0]              pinOe,
	output logic [3:0]              pinClaim
);
	if (NUM_TIMERS < 1 || NUM_TIMERS > 3)
	begin
		$error("NUM_TIMERS must be 1 to 3");
	end

	typedef struct packed
	{
		logic [7:0]                 control;
		logic [7:0]                 dutyBuf;
		logic [7:0]                 dutyAct;
		logic [1:0]                 lowLatch;
		logic [1:0]                 tsel;
		logic [NUM_TIMERS-1:0][6:0] tctl;
		logic [NUM_TIMERS-1:0][7:0] plim;
		logic [NUM_TIMERS-1:0]      flag;
		logic [NUM_TIMERS-1:0][3:0] post;
		logic [3:0]                 pinDir;
		logic [3:0]                 steer;
		arm_type                    arm;
		logic                       raw;
		logic [3:0]                 pinOut;
		logic [3:0]                 pinOe;
		logic [3:0]                 pinClaim;
		logic [31:0]                rdata;
	} state_type;

	state_type  st_ff;
	state_type  nxt_st;
	logic [4:0] idx;
	logic       wrEn;
	logic       pwmOn;
	logic       wrapSel;
	logic [9:0] tbSel;
	logic [7:0] route;
	logic [3:0] inv;

	pwm_timer_if #(.NT(NUM_TIMERS)) tif ();

	ccp_period_timers #(.NT(NUM_TIMERS)) timers
	(
		.ref_clk (ref_clk),
		.srst    (srst),
		.tif     (tif)
	);

	// aligned word decode; anything else is answered with an error
	function automatic logic [4:0] reg_index(input logic [`ADDR_W-1:0] a);
		reg_index = `REG_NONE;
		case (a)
			`OFS_PWM_CONTROL: reg_index = `REG_CONTROL;
			`OFS_DUTY_BUF:    reg_index = `REG_DUTY_BUF;
			`OFS_DUTY_ACT:    reg_index = `REG_DUTY_ACT;
			`OFS_TSEL:        reg_index = `REG_TSEL;
			`OFS_STATUS:      reg_index = `REG_STATUS;
			`OFS_PIN_DIR:     reg_index = `REG_PIN_DIR;
			`OFS_STEER:       reg_index = `REG_STEER;
			default:
			begin
				for (int i = 0; i < NUM_TIMERS; i++)
				begin
					if (a == `OFS_TCTL0 + 8'(4 * i))
						reg_index = `REG_TCTL0 + 5'(i);
					if (a == `OFS_PLIM0 + 8'(4 * i))
						reg_index = `REG_PLIM0 + 5'(i);
					if (a == `OFS_PCNT0 + 8'(4 * i))
						reg_index = `REG_PCNT0 + 5'(i);
				end
			end
		endcase
	endfunction

	// upper nibble is the per-pin claim, lower nibble the active levels before polarity (D..A)
	function automatic logic [7:0] route_pins(input logic [1:0] mode, input logic p,
		input logic [3:0] steer);
		case (mode)
			MODE_SINGLE:   route_pins = {steer, steer & {4{p}}};
			MODE_HALF:     route_pins = {4'b0011, 2'b00, ~p, p};
			MODE_FULL_FWD: route_pins = {4'b1111, p, 3'b001};
			MODE_FULL_REV: route_pins = {4'b1111, 2'b01, p, 1'b0};
			default:       route_pins = 8'h00;
		endcase
	endfunction

	always_comb
	begin
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			tif.runEnable[i]   = st_ff.tctl[i][`TCTL_RUN_BIT];
			tif.prescale[i]    = st_ff.tctl[i][1:0];
			tif.periodLimit[i] = st_ff.plim[i];
		end
	end

	assign idx   = reg_index(paddr);
	assign wrEn  = psel && penable && pwrite;
	assign pwmOn = st_ff.control[3:2] == `CTL_PWM_ON;

	always_comb
	begin
		wrapSel = 1'b0;
		tbSel   = 10'h000;
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (st_ff.tsel == 2'(i))
			begin
				wrapSel = tif.wrapNow[i];
				tbSel   = tif.timeBaseNext[i];
			end
		end
	end

	always_comb
	begin
		nxt_st = st_ff;
		route  = 8'h00;
		inv    = 4'h0;

		if (wrEn)
		begin
			case (idx)
				`REG_CONTROL:  nxt_st.control = pwdata[7:0];
				`REG_DUTY_BUF: nxt_st.dutyBuf = pwdata[7:0];
				`REG_DUTY_ACT:
				begin
					if (!pwmOn)
						nxt_st.dutyAct = pwdata[7:0];
				end
				`REG_TSEL:     nxt_st.tsel = pwdata[1:0];
				`REG_STATUS:   nxt_st.flag = st_ff.flag & ~pwdata[NUM_TIMERS-1:0];
				`REG_PIN_DIR:  nxt_st.pinDir = pwdata[3:0];
				`REG_STEER:    nxt_st.steer = pwdata[3:0];
				default:
				begin
					for (int i = 0; i < NUM_TIMERS; i++)
					begin
						if (idx == `REG_TCTL0 + 5'(i))
							nxt_st.tctl[i] = pwdata[6:0];
						if (idx == `REG_PLIM0 + 5'(i))
							nxt_st.plim[i] = pwdata[7:0];
					end
				end
			endcase
		end

		// postscaled match flag; a new match beats a clear in the same cycle
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (tif.wrapNow[i])
			begin
				if (st_ff.post[i] == st_ff.tctl[i][`TCTL_POST_LSB +: 4])
				begin
					nxt_st.post[i] = 4'h0;
					nxt_st.flag[i] = 1'b1;
				end
				else
					nxt_st.post[i] = st_ff.post[i] + 4'h1;
			end
		end

		case (st_ff.arm)
			ARM_IDLE:
			begin
				if (pwmOn)
					nxt_st.arm = ARM_WAIT;
			end
			ARM_WAIT:
			begin
				if (!pwmOn)
					nxt_st.arm = ARM_IDLE;
				else if (wrapSel)
					nxt_st.arm = ARM_RUN;
			end
			ARM_RUN:
			begin
				if (!pwmOn)
					nxt_st.arm = ARM_IDLE;
			end
			default: nxt_st.arm = ARM_IDLE;
		endcase

		if (pwmOn && wrapSel)
		begin
			nxt_st.dutyAct  = st_ff.dutyBuf;
			nxt_st.lowLatch = st_ff.control[`CTL_LOW_LSB +: 2];
			nxt_st.raw      = {st_ff.dutyBuf, st_ff.control[`CTL_LOW_LSB +: 2]} != 10'h000;
		end
		else if (!pwmOn)
			nxt_st.raw = 1'b0;
		else if (st_ff.raw && tbSel == {st_ff.dutyAct, st_ff.lowLatch})
			nxt_st.raw = 1'b0;

		route = route_pins(st_ff.control[`CTL_MODE_LSB +: 2],
			nxt_st.raw && nxt_st.arm == ARM_RUN, st_ff.steer);
		inv   = {st_ff.control[0], st_ff.control[1], st_ff.control[0], st_ff.control[1]};
		nxt_st.pinClaim = pwmOn ? route[7:4] : 4'h0;
		nxt_st.pinOut   = nxt_st.pinClaim & (route[3:0] ^ inv);
		nxt_st.pinOe    = nxt_st.pinClaim & ~st_ff.pinDir;

		if (psel && !penable)
		begin
			nxt_st.rdata = 32'h0000_0000;
			case (idx)
				`REG_CONTROL:  nxt_st.rdata[7:0] = st_ff.control;
				`REG_DUTY_BUF: nxt_st.rdata[7:0] = st_ff.dutyBuf;
				`REG_DUTY_ACT: nxt_st.rdata[7:0] = st_ff.dutyAct;
				`REG_TSEL:     nxt_st.rdata[1:0] = st_ff.tsel;
				`REG_STATUS:
				begin
					nxt_st.rdata[NUM_TIMERS-1:0] = st_ff.flag;
					nxt_st.rdata[5:4] = st_ff.arm;
					nxt_st.rdata[6]   = st_ff.raw;
				end
				`REG_PIN_DIR:  nxt_st.rdata[3:0] = st_ff.pinDir;
				`REG_STEER:    nxt_st.rdata[3:0] = st_ff.steer;
				default:
				begin
					for (int i = 0; i < NUM_TIMERS; i++)
					begin
						if (idx == `REG_TCTL0 + 5'(i))
							nxt_st.rdata[6:0] = st_ff.tctl[i];
						if (idx == `REG_PLIM0 + 5'(i))
							nxt_st.rdata[7:0] = st_ff.plim[i];
						if (idx == `REG_PCNT0 + 5'(i))
							nxt_st.rdata[7:0] = tif.count[i];
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			st_ff        <= '0;
			st_ff.plim   <= {NUM_TIMERS{`PLIM_RST}};
			st_ff.tctl   <= {NUM_TIMERS{`TCTL_RST}};
			st_ff.pinDir <= `PIN_DIR_RST;
			st_ff.steer  <= `STEER_RST;
			st_ff.arm    <= ARM_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// zero-wait slave: read data is captured in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && idx == `REG_NONE;
	assign prdata   = st_ff.rdata;
	assign pinOut   = st_ff.pinOut;
	assign pinOe    = st_ff.pinOe;
	assign pinClaim = st_ff.pinClaim;
endmodule

// >>> testbench/ccp_pwm_sva.sv
// concurrent checks on the pins and bus answers of the pwm generator
`include "ccp_pwm_consts.svh"
module ccp_pwm_sva
(
	input wire logic                ref_clk,
	input wire logic                srst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [`ADDR_W-1:0]  paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [3:0]          pinOut,
	input wire logic [3:0]          pinOe,
	input wire logic [3:0]          pinClaim
);
	logic       wr;
	logic [7:0] ctl_ff;
	logic [3:0] dir_ff;

	// shadow copies of control and direction, taken from the bus itself
	assign wr = psel && penable && pwrite;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ctl_ff <= 8'h00;
			dir_ff <= 4'hf;
		end
		else if (wr && paddr == `OFS_PWM_CONTROL)
			ctl_ff <= pwdata[7:0];
		else if (wr && paddr == `OFS_PIN_DIR)
			dir_ff <= pwdata[3:0];
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	pin_release_a: assert property (wr && paddr == `OFS_PWM_CONTROL && pwdata[3:2] != 2'b11
		|-> ##[1:3] pinClaim == 4'h0) else $error("pins kept after pwm off");
	oe_claim_a: assert property ((pinOe & ~pinClaim) == 4'h0)
		else $error("drive on unclaimed pin");
	free_low_a: assert property ((pinOut & ~pinClaim) == 4'h0)
		else $error("level on unclaimed pin");
	// masked by the two older copies so the register lag is tolerated
	dir_gate_a: assert property ((pinOe & dir_ff & $past(dir_ff) & $past(dir_ff, 2)) == 4'h0)
		else $error("pin driven while input");
	half_safe_a: assert property (ctl_ff[7:6] == 2'b10 && ctl_ff[3:0] == 4'hc
		&& $past(ctl_ff, 3) == ctl_ff |-> !(pinOut[0] && pinOut[1])) else $error("half overlap");
	fwd_route_a: assert property (ctl_ff[7:6] == 2'b01 && ctl_ff[3:0] == 4'hc
		&& $past(ctl_ff, 3) == ctl_ff |-> pinOut[2:1] == 2'b00) else $error("fwd b/c active");
	rev_route_a: assert property (ctl_ff[7:6] == 2'b11 && ctl_ff[3:0] == 4'hc
		&& $past(ctl_ff, 3) == ctl_ff |-> !pinOut[0] && !pinOut[3]) else $error("rev a/d active");
	bad_addr_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access accepted");
endmodule

bind ccp_pwm_gen ccp_pwm_sva chk_i (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .pinOut, .pinOe, .pinClaim);

// >>> testbench/pwm_load_model.sv
// load on the pwm pins: pull-downs, and period and high time measured on pin a
module pwm_load_model
(
	input wire logic        ref_clk,
	input wire logic [3:0]  pinOut,
	input wire logic [3:0]  pinOe,
	output logic [3:0]      level,
	output logic [15:0]     highLen,
	output logic [15:0]     periodLen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        last_ff;
	logic [15:0] run_ff;
	logic [15:0] hi_ff;

	// a released pin is pulled low by the load, never left at its last value
	assign level = pinOut & pinOe;
	always @(posedge ref_clk)
	begin
		last_ff <= level[0];
		if (level[0] && !last_ff)
		begin
			periodLen <= run_ff;
			highLen <= hi_ff;
			run_ff <= 16'h1;
			hi_ff <= 16'h1;
		end
		else
		begin
			run_ff <= run_ff + 16'h1;
			hi_ff <= hi_ff + {15'h0, level[0]};
		end
	end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the capture/compare pwm generator
`include "ccp_pwm_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pinOut;
	logic [3:0]  pinOe;
	logic [3:0]  pinClaim;
	logic [3:0]  level;
	logic [15:0] highLen;
	logic [15:0] periodLen;
	logic        errSeen;
	logic [31:0] q;
	logic [31:0] c;
	int          err_count = 0;
	int          total_checks = 0;
	logic [7:0]  tctl [3] = '{8'h7c, 8'h05, 8'h06};
	logic [15:0] perE [3] = '{16'h0014, 16'h0050, 16'h0140};
	logic [15:0] hiE  [3] = '{16'h000d, 16'h0034, 16'h00d0};
	logic [7:0]  mCtl [7] = '{8'h0c, 8'h0c, 8'h8c, 8'h4c, 8'hcc, 8'h8f, 8'h4f};
	logic [3:0]  mStr [7] = '{4'h1, 4'hf, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
	logic [3:0]  mClm [7] = '{4'h1, 4'hf, 4'h3, 4'hf, 4'hf, 4'h3, 4'hf};
	logic [31:0] mCnt [7] = '{32'h00000008, 32'h08080808, 32'h00000c08, 32'h08000014,
		32'h00140800, 32'h0000080c, 32'h0c141400};

	ccp_pwm_gen uut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pinOut, .pinOe, .pinClaim);
	pwm_load_model load (.ref_clk, .pinOut, .pinOe, .level, .highLen, .periodLen);

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic finish_test;
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a wait
		do
		begin
			@(posedge ref_clk);
		end
		while (pready !== 1'b1);
		r = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	// one period of 20 cycles, high samples per pin counted into bytes
	task automatic sample(output logic [31:0] r);
		r = 32'h0;
		repeat (20)
		begin
			@(posedge ref_clk);
			for (int i = 0; i < 4; i++)
				r[i*8 +: 8] += {7'h0, level[i]};
		end
	endtask

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		finish_test();
	end

	initial
	begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk({20'h0, pinOut, pinOe, pinClaim}, 32'h0);
		rd(`OFS_PWM_CONTROL, 32'h0);
		rd(`OFS_PLIM0, 32'hff);
		rd(`OFS_PIN_DIR, 32'hf);
		rd(`OFS_STEER, 32'h1);
		rd(`OFS_TCTL0, 32'h0);
		apb(1'b0, 8'h40, 32'h0, q);
		chk({31'h0, errSeen}, 32'h1);
		apb(1'b1, 8'h06, 32'hff, q);
		chk({31'h0, errSeen}, 32'h1);
		rd(`OFS_DUTY_BUF, 32'h0);
		wr(`OFS_PLIM0, 32'h4);
		wr(`OFS_DUTY_BUF, 32'h3);
		wr(`OFS_PWM_CONTROL, 32'h1c);
		wr(`OFS_STATUS, 32'h7);
		wr(`OFS_TCTL0, 32'h7c);
		q = 32'h0;
		// sixteen wraps of 20 cycles pass before the postscaled flag rises
		for (int n = 0; n < 200 && !q[0]; n++)
			apb(1'b0, `OFS_STATUS, 32'h0, q);
		chk({31'h0, q[0]}, 32'h1);
		wr(`OFS_PIN_DIR, 32'he);
		for (int i = 0; i < 3; i++)
		begin
			wr(`OFS_TCTL0, {24'h0, tctl[i]});
			repeat (1000) @(posedge ref_clk);
			chk({16'h0, periodLen}, {16'h0, perE[i]});
			chk({16'h0, highLen}, {16'h0, hiE[i]});
		end
		// act just after a boundary so no wrap falls between the accesses
		@(posedge level[0]);
		@(posedge ref_clk);
		wr(`OFS_DUTY_BUF, 32'h2);
		wr(`OFS_DUTY_ACT, 32'h55);
		rd(`OFS_DUTY_ACT, 32'h3);
		repeat (700) @(posedge ref_clk);
		rd(`OFS_DUTY_ACT, 32'h2);
		chk({16'h0, highLen}, 32'h90);
		wr(`OFS_DUTY_BUF, 32'h1);
		wr(8'h20, 32'h1);
		wr(8'h14, 32'h4);
		wr(`OFS_TSEL, 32'h1);
		repeat (200) @(posedge ref_clk);
		chk({highLen, periodLen}, 32'h00050008);
		wr(`OFS_TSEL, 32'h0);
		wr(`OFS_TCTL0, 32'h4);
		wr(`OFS_DUTY_BUF, 32'h0);
		wr(`OFS_PWM_CONTROL, 32'h0c);
		repeat (700) @(posedge ref_clk);
		sample(c);
		chk(c & 32'hff, 32'h0);
		wr(`OFS_DUTY_BUF, 32'h2);
		wr(`OFS_PIN_DIR, 32'h0);
		for (int i = 0; i < 7; i++)
		begin
			wr(`OFS_STEER, {28'h0, mStr[i]});
			wr(`OFS_PWM_CONTROL, {24'h0, mCtl[i]});
			repeat (60) @(posedge ref_clk);
			sample(c);
			chk(c, mCnt[i]);
			chk({28'h0, pinClaim}, {28'h0, mClm[i]});
		end
		wr(`OFS_PIN_DIR, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk({28'h0, pinOe}, 32'hd);
		wr(`OFS_PWM_CONTROL, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk({24'h0, pinClaim, pinOe}, 32'h0);
		// re-enable with the timer halted: output must wait for a fresh period
		wr(`OFS_TCTL0, 32'h0);
		apb(1'b0, `OFS_PCNT0, 32'h0, c);
		wr(`OFS_PWM_CONTROL, 32'h0c);
		repeat (40) @(posedge ref_clk);
		rd(`OFS_PCNT0, c);
		apb(1'b0, `OFS_STATUS, 32'h0, q);
		chk(q & 32'h70, 32'h10);
		chk({28'h0, pinOut}, 32'h0);
		wr(`OFS_TCTL0, 32'h4);
		repeat (40) @(posedge ref_clk);
		apb(1'b0, `OFS_STATUS, 32'h0, q);
		chk(q & 32'h30, 32'h20);
		finish_test();
	end
endmodule
